//--- dam_mapper.sv
`timescale 1ns/1ns
module dam_mapper
	import dam_pkg::*;
(
	// clock and reset
	input  wire logic  i_core_clk,
	input  wire logic  i_reset,
	// translation port
	dam_xlat_if.mapper xif
);

	typedef struct packed {
		logic                  valid;
		logic [DAM_BANK_W-1:0] bank;
		logic [DAM_ROW_W-1:0]  row;
		logic [DAM_COL_W-1:0]  col;
		logic                  chan;
		logic                  rsvd;
	} dam_map_st_t;

	dam_map_st_t st_ff;
	dam_map_st_t nxt;
	logic [DAM_PA_W-1:0] a;

	always_comb begin
		nxt = '0;
		// ganged: bit 3 picks the channel, table bits move up one
		a = xif.req_gang ? (xif.req_addr >> 1) : xif.req_addr;
		nxt.valid = xif.req_valid;
		nxt.chan = xif.req_gang & xif.req_addr[3];
		nxt.col[9:0] = a[12:3];
		unique case (xif.req_code)
			4'h0: begin
				nxt.bank = {1'b0, a[13:12]};
				nxt.row[12:0] = {a[17:14], a[26:18]};
				nxt.col[9:0] = {1'b0, a[11:3]};
			end
			4'h1: begin
				nxt.bank = {1'b0, a[14:13]};
				nxt.row[12:0] = {a[17:15], a[27:18]};
			end
			4'h2: begin
				nxt.bank = {1'b0, a[14:13]};
				nxt.row[13:0] = {a[17:15], a[28:18]};
			end
			4'h3: begin
				nxt.bank = {1'b0, a[15:14]};
				nxt.row[12:0] = {a[17:16], a[28:18]};
				nxt.col[11] = a[13];
			end
			4'h4: begin
				nxt.bank = a[15:13];
				nxt.row[12:0] = {a[17:16], a[28:18]};
			end
			4'h5: begin
				nxt.bank = a[15:13];
				nxt.row[13:0] = {a[17:16], a[29:18]};
			end
			4'h6: begin
				nxt.bank = {1'b0, a[15:14]};
				nxt.row[13:0] = {a[17:16], a[29:18]};
				nxt.col[11] = a[13];
			end
			4'h7: begin
				nxt.bank = a[15:13];
				nxt.row[14:0] = {a[17:16], a[30:18]};
			end
			4'h8: begin
				nxt.bank = a[16:14];
				nxt.row[13:0] = {a[17], a[30:18]};
				nxt.col[11] = a[13];
			end
			4'h9: begin
				nxt.bank = a[16:14];
				nxt.row[14:0] = {a[17], a[31:18]};
				nxt.col[11] = a[13];
			end
			4'hA: begin
				nxt.bank = a[15:13];
				nxt.row[15:0] = {a[17:16], a[31:18]};
			end
			4'hB: begin
				nxt.bank = a[16:14];
				nxt.row[15:0] = {a[17], a[32:18]};
				nxt.col[11] = a[13];
			end
			default: begin
				nxt.col = '0;
				nxt.rsvd = 1'b1;
			end
		endcase
		nxt.col[DAM_AP_POS] = xif.req_ap & ~nxt.rsvd;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt;
		end
	end

	assign xif.rsp_valid = st_ff.valid;
	assign xif.rsp_bank  = st_ff.bank;
	assign xif.rsp_row   = st_ff.row;
	assign xif.rsp_col   = st_ff.col;
	assign xif.rsp_chan  = st_ff.chan;
	assign xif.rsp_rsvd  = st_ff.rsvd;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	property p_gang_chan;
		xif.req_valid && xif.req_gang |=>
			xif.rsp_chan == $past(xif.req_addr[3]);
	endproperty
	a_gang_chan: assert property (p_gang_chan)
		else $error("ganged channel bit wrong");

	property p_code0_row;
		xif.req_valid && !xif.req_gang && xif.req_code == 4'h0 |=>
			xif.rsp_row[8:0] == $past(xif.req_addr[26:18]) &&
			xif.rsp_bank[1:0] == $past(xif.req_addr[13:12]);
	endproperty
	a_code0_row: assert property (p_code0_row)
		else $error("code 0 row or bank wrong");

	property p_code7_gang;
		xif.req_valid && xif.req_gang && xif.req_code == 4'h7 |=>
			xif.rsp_row[12:0] == $past(xif.req_addr[31:19]);
	endproperty
	a_code7_gang: assert property (p_code7_gang)
		else $error("ganged code 7 row not shifted");

	property p_ap_col;
		xif.req_valid && xif.req_code <= DAM_CODE_LAST |=>
			xif.rsp_col[DAM_AP_POS] == $past(xif.req_ap);
	endproperty
	a_ap_col: assert property (p_ap_col)
		else $error("auto precharge column wrong");

endmodule : dam_mapper

//--- dam_pkg.sv
package dam_pkg;

	// register byte offsets
	localparam logic [7:0]  DAM_OFF_INIT_CMD = 8'h7C;
	localparam logic [7:0]  DAM_OFF_MAP      = 8'h80;
	localparam logic [7:0]  DAM_OFF_CFG      = 8'h90;
	localparam logic [7:0]  DAM_OFF_STAT     = 8'h94;

	// init command register fields
	localparam int          DAM_ISSUE_BIT    = 26;
	localparam int          DAM_TCS_LSB      = 20;
	localparam int          DAM_TCS_W        = 3;
	localparam int          DAM_MBANK_LSB    = 16;
	localparam int          DAM_MBANK_W      = 3;
	localparam int          DAM_MADDR_LSB    = 0;
	localparam int          DAM_MADDR_W      = 16;

	// map register fields
	localparam int          DAM_CODE_W       = 4;
	localparam int          DAM_NUM_DIMM     = 4;
	localparam int          DAM_MAP_W        = 16;

	// config register bits
	localparam int          DAM_CFG_INIT_BIT = 0;
	localparam int          DAM_CFG_DDR3_BIT = 1;
	localparam int          DAM_CFG_RDIM_BIT = 2;
	localparam int          DAM_CFG_GANG_BIT = 3;

	// status register bits
	localparam int          DAM_STAT_BUSY    = 0;
	localparam int          DAM_STAT_RSVD    = 1;

	// reset values
	localparam logic [15:0] DAM_MAP_RST      = 16'h0000;
	localparam logic [15:0] DAM_MADDR_RST    = 16'h0000;
	localparam logic [2:0]  DAM_FLD3_RST     = 3'h0;

	// translation widths
	localparam int          DAM_PA_W         = 40;
	localparam int          DAM_ROW_W        = 16;
	localparam int          DAM_COL_W        = 16;
	localparam int          DAM_BANK_W       = 3;
	localparam int          DAM_AP_POS       = 10;
	localparam logic [3:0]  DAM_CODE_LAST    = 4'hB;
	localparam logic [7:0]  DAM_CS_ALL       = 8'hFF;

	typedef enum logic [1:0] {
		DAM_IDLE = 2'b00,
		DAM_BUSY = 2'b01
	} dam_mode_st_t;

endpackage : dam_pkg

//--- dam_seq_model.sv
`timescale 1ns/1ns
module dam_seq_model (
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_reset,
	// answer speed: 0 prompt, 1 slow
	input  wire logic        i_slow,
	// mode command from the block
	input  wire logic        i_mode_cmd_valid,
	input  wire logic [7:0]  i_mode_cmd_cs,
	input  wire logic [2:0]  i_mode_cmd_bank,
	input  wire logic [15:0] i_mode_cmd_addr,
	output logic             o_mode_cmd_done,
	// what the far side saw
	output logic [7:0]       o_cmd_count,
	output logic [7:0]       o_last_cs,
	output logic [2:0]       o_last_bank,
	output logic [15:0]      o_last_addr
);
	logic [3:0] wait_ff;
	logic       busy_ff;

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			wait_ff         <= 4'h0;
			busy_ff         <= 1'b0;
			o_mode_cmd_done <= 1'b0;
			o_cmd_count     <= 8'h00;
			o_last_cs       <= 8'h00;
			o_last_bank     <= 3'h0;
			o_last_addr     <= 16'h0000;
		end else begin
			o_mode_cmd_done <= 1'b0;
			if (i_mode_cmd_valid) begin
				busy_ff     <= 1'b1;
				wait_ff     <= i_slow ? 4'h6 : 4'h0;
				o_cmd_count <= o_cmd_count + 8'h01;
				o_last_cs   <= i_mode_cmd_cs;
				o_last_bank <= i_mode_cmd_bank;
				o_last_addr <= i_mode_cmd_addr;
			end else if (busy_ff) begin
				// completion ends the command on the far side
				if (wait_ff == 4'h0) begin
					o_mode_cmd_done <= 1'b1;
					busy_ff         <= 1'b0;
				end else begin
					wait_ff <= wait_ff - 4'h1;
				end
			end
		end
	end
endmodule : dam_seq_model

//--- dam_top.sv
`timescale 1ns/1ns
module dam_top
	import dam_pkg::*;
(
	// clock and reset
	input  wire logic                  i_core_clk,
	input  wire logic                  i_reset,
	// apb slave
	input  wire logic                  i_psel,
	input  wire logic                  i_penable,
	input  wire logic                  i_pwrite,
	input  wire logic [7:0]            i_paddr,
	input  wire logic [31:0]           i_pwdata,
	output logic      [31:0]           o_prdata,
	output logic                       o_pready,
	output logic                       o_pslverr,
	// mode register command to the sequencer
	output logic                       o_mode_cmd_valid,
	output logic      [7:0]            o_mode_cmd_cs,
	output logic      [DAM_MBANK_W-1:0] o_mode_cmd_bank,
	output logic      [DAM_MADDR_W-1:0] o_mode_cmd_addr,
	input  wire logic                  i_mode_cmd_done,
	// address translation request
	input  wire logic                  i_xlat_valid,
	input  wire logic [1:0]            i_xlat_dimm,
	input  wire logic [DAM_PA_W-1:0]   i_xlat_addr,
	input  wire logic                  i_xlat_ap,
	// address translation result
	output logic                       o_xlat_valid,
	output logic      [DAM_BANK_W-1:0] o_xlat_bank,
	output logic      [DAM_ROW_W-1:0]  o_xlat_row,
	output logic      [DAM_COL_W-1:0]  o_xlat_col,
	output logic                       o_xlat_channel,
	output logic                       o_xlat_reserved
);

	typedef struct packed {
		logic                   pready;
		logic                   pslverr;
		logic [31:0]            prdata;
		logic [DAM_MAP_W-1:0]   map;
		logic                   issue;
		logic [DAM_TCS_W-1:0]   tcs;
		logic [DAM_MBANK_W-1:0] mbank;
		logic [DAM_MADDR_W-1:0] maddr;
		logic                   init_en;
		logic                   ddr3;
		logic                   rdimm;
		logic                   gang;
		dam_mode_st_t           st;
		logic                   cmd_valid;
		logic [7:0]             cmd_cs;
		logic [DAM_MBANK_W-1:0] cmd_bank;
		logic [DAM_MADDR_W-1:0] cmd_addr;
	} dam_top_st_t;

	dam_top_st_t st_ff;
	dam_top_st_t nxt;
	logic        acc;
	logic        wr;
	logic        setup;

	dam_xlat_if xif ();

	function automatic logic [7:0] cs_onehot(input logic [2:0] s);
		cs_onehot = 8'h01 << s;
	endfunction : cs_onehot

	function automatic logic reg_known(input logic [7:0] a);
		reg_known = (a == DAM_OFF_INIT_CMD) || (a == DAM_OFF_MAP) ||
			(a == DAM_OFF_CFG) || (a == DAM_OFF_STAT);
	endfunction : reg_known

	// chip select mask for a mode register command
	function automatic logic [7:0] cmd_mask(input dam_top_st_t s);
		if (s.ddr3 && s.rdimm) begin
			// registered DDR3 parts honour the field only in software init
			cmd_mask = s.init_en ? cs_onehot(s.tcs) : DAM_CS_ALL;
		end else begin
			cmd_mask = s.init_en ? DAM_CS_ALL : cs_onehot(s.tcs);
		end
	endfunction : cmd_mask

	// translation goes straight to the mapper, one cycle of latency
	assign xif.req_valid = i_xlat_valid;
	assign xif.req_addr  = i_xlat_addr;
	assign xif.req_code  = st_ff.map[i_xlat_dimm*DAM_CODE_W +: DAM_CODE_W];
	assign xif.req_ap    = i_xlat_ap;
	assign xif.req_gang  = st_ff.gang;

	dam_mapper u_mapper (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.xif        (xif.mapper)
	);

	always_comb begin
		nxt = st_ff;
		setup = i_psel & ~i_penable;
		acc = i_psel & i_penable & st_ff.pready;
		wr = acc & i_pwrite & ~st_ff.pslverr;
		nxt.pready = setup;
		nxt.cmd_valid = 1'b0;

		// read data and error are captured in the setup cycle
		if (setup) begin
			nxt.pslverr = ~reg_known(i_paddr);
			nxt.prdata = '0;
			if (i_paddr == DAM_OFF_INIT_CMD) begin
				nxt.prdata[DAM_ISSUE_BIT] = st_ff.issue;
				nxt.prdata[DAM_TCS_LSB +: DAM_TCS_W] = st_ff.tcs;
				nxt.prdata[DAM_MBANK_LSB +: DAM_MBANK_W] = st_ff.mbank;
				nxt.prdata[DAM_MADDR_LSB +: DAM_MADDR_W] = st_ff.maddr;
			end
			if (i_paddr == DAM_OFF_MAP) begin
				nxt.prdata[DAM_MAP_W-1:0] = st_ff.map;
			end
			if (i_paddr == DAM_OFF_CFG) begin
				nxt.prdata[DAM_CFG_INIT_BIT] = st_ff.init_en;
				nxt.prdata[DAM_CFG_DDR3_BIT] = st_ff.ddr3;
				nxt.prdata[DAM_CFG_RDIM_BIT] = st_ff.rdimm;
				nxt.prdata[DAM_CFG_GANG_BIT] = st_ff.gang;
			end
			if (i_paddr == DAM_OFF_STAT) begin
				nxt.prdata[DAM_STAT_BUSY] = (st_ff.st == DAM_BUSY);
				nxt.prdata[DAM_STAT_RSVD] = xif.rsp_rsvd;
			end
		end else if (acc) begin
			nxt.pslverr = 1'b0;
		end

		// mode command sequencing
		unique case (st_ff.st)
			DAM_IDLE: begin
				if (st_ff.issue) begin
					nxt.st = DAM_BUSY;
					nxt.cmd_valid = 1'b1;
					nxt.cmd_cs = cmd_mask(st_ff);
					nxt.cmd_bank = st_ff.mbank;
					nxt.cmd_addr = st_ff.maddr;
				end
			end
			DAM_BUSY: begin
				if (i_mode_cmd_done) begin
					nxt.st = DAM_IDLE;
					nxt.issue = 1'b0;
				end
			end
			default: begin
				nxt.st = DAM_IDLE;
			end
		endcase

		// register writes come last so a new issue beats the clear
		if (wr && i_paddr == DAM_OFF_INIT_CMD) begin
			nxt.tcs = i_pwdata[DAM_TCS_LSB +: DAM_TCS_W];
			nxt.mbank = i_pwdata[DAM_MBANK_LSB +: DAM_MBANK_W];
			nxt.maddr = i_pwdata[DAM_MADDR_LSB +: DAM_MADDR_W];
			if (i_pwdata[DAM_ISSUE_BIT]) begin
				nxt.issue = 1'b1;
			end
		end
		if (wr && i_paddr == DAM_OFF_MAP) begin
			nxt.map = i_pwdata[DAM_MAP_W-1:0];
		end
		if (wr && i_paddr == DAM_OFF_CFG) begin
			nxt.init_en = i_pwdata[DAM_CFG_INIT_BIT];
			nxt.ddr3 = i_pwdata[DAM_CFG_DDR3_BIT];
			nxt.rdimm = i_pwdata[DAM_CFG_RDIM_BIT];
			nxt.gang = i_pwdata[DAM_CFG_GANG_BIT];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			st_ff <= '0;
			st_ff.map <= DAM_MAP_RST;
			st_ff.tcs <= DAM_FLD3_RST;
			st_ff.mbank <= DAM_FLD3_RST;
			st_ff.maddr <= DAM_MADDR_RST;
			st_ff.st <= DAM_IDLE;
		end else begin
			st_ff <= nxt;
		end
	end

	assign o_prdata         = st_ff.prdata;
	assign o_pready         = st_ff.pready;
	assign o_pslverr        = st_ff.pslverr;
	assign o_mode_cmd_valid = st_ff.cmd_valid;
	assign o_mode_cmd_cs    = st_ff.cmd_cs;
	assign o_mode_cmd_bank  = st_ff.cmd_bank;
	assign o_mode_cmd_addr  = st_ff.cmd_addr;
	assign o_xlat_valid     = xif.rsp_valid;
	assign o_xlat_bank      = xif.rsp_bank;
	assign o_xlat_row       = xif.rsp_row;
	assign o_xlat_col       = xif.rsp_col;
	assign o_xlat_channel   = xif.rsp_chan;
	assign o_xlat_reserved  = xif.rsp_rsvd;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	logic launch;
	assign launch = st_ff.st == DAM_IDLE && st_ff.issue;

	property p_cs_field;
		launch && !st_ff.init_en && !(st_ff.ddr3 && st_ff.rdimm) |=>
			o_mode_cmd_valid &&
			o_mode_cmd_cs == cs_onehot($past(st_ff.tcs));
	endproperty
	a_cs_field: assert property (p_cs_field)
		else $error("mode command chip select mismatch");

	property p_cs_all_init;
		launch && st_ff.init_en && !(st_ff.ddr3 && st_ff.rdimm) |=>
			o_mode_cmd_valid && o_mode_cmd_cs == DAM_CS_ALL;
	endproperty
	a_cs_all_init: assert property (p_cs_all_init)
		else $error("init command not sent to all selects");

	property p_cs_rdimm;
		launch && st_ff.init_en && st_ff.ddr3 && st_ff.rdimm |=>
			o_mode_cmd_cs == cs_onehot($past(st_ff.tcs));
	endproperty
	a_cs_rdimm: assert property (p_cs_rdimm)
		else $error("registered dimm init select mismatch");

	property p_issue_start;
		wr && i_paddr == DAM_OFF_INIT_CMD && i_pwdata[DAM_ISSUE_BIT] &&
			st_ff.st == DAM_IDLE && !st_ff.issue
			|=> st_ff.issue ##1 o_mode_cmd_valid;
	endproperty
	a_issue_start: assert property (p_issue_start)
		else $error("issue write did not launch command");

	property p_issue_clear;
		st_ff.st == DAM_BUSY && i_mode_cmd_done && !wr |=>
			(!st_ff.issue && !o_mode_cmd_valid) ##1 !o_mode_cmd_valid;
	endproperty
	a_issue_clear: assert property (p_issue_clear)
		else $error("issue bit not cleared on completion");

	// the pulse stands in the first busy cycle and never stands two cycles
	property p_single_pulse;
		o_mode_cmd_valid |-> st_ff.st == DAM_BUSY ##1 !o_mode_cmd_valid;
	endproperty
	a_single_pulse: assert property (p_single_pulse)
		else $error("mode command pulse repeated");

	property p_map_write;
		wr && i_paddr == DAM_OFF_MAP |=>
			st_ff.map == $past(i_pwdata[DAM_MAP_W-1:0]);
	endproperty
	a_map_write: assert property (p_map_write)
		else $error("map register write lost");

	property p_map_read;
		acc && !i_pwrite && i_paddr == DAM_OFF_MAP |->
			o_prdata[31:DAM_MAP_W] == '0 &&
			o_prdata[DAM_MAP_W-1:0] == st_ff.map;
	endproperty
	a_map_read: assert property (p_map_read)
		else $error("map register read wrong");

	property p_rsvd_code;
		i_xlat_valid &&
			st_ff.map[i_xlat_dimm*DAM_CODE_W +: DAM_CODE_W] > DAM_CODE_LAST
			|=> o_xlat_valid && o_xlat_reserved;
	endproperty
	a_rsvd_code: assert property (p_rsvd_code)
		else $error("reserved code not flagged");

	property p_dimm_code;
		i_xlat_valid && !st_ff.gang && i_xlat_dimm == 2'h3 &&
			st_ff.map[15:12] == 4'h0 |=>
			o_xlat_bank == {1'b0, $past(i_xlat_addr[13:12])};
	endproperty
	a_dimm_code: assert property (p_dimm_code)
		else $error("dimm 3 code not applied");

	property p_apb_ready;
		i_psel && !i_penable |=> o_pready ##1 !o_pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready)
		else $error("apb ready timing wrong");

	c_cmd_busy: cover property (o_mode_cmd_valid ##[1:20] i_mode_cmd_done);
	c_map_xlat: cover property (wr && i_paddr == DAM_OFF_MAP
		##[1:10] o_xlat_valid);
	c_unmapped: cover property (acc && st_ff.pslverr);

endmodule : dam_top

//--- dam_xlat_if.sv
`timescale 1ns/1ns
interface dam_xlat_if;
	import dam_pkg::*;
	logic                  req_valid;
	logic [DAM_PA_W-1:0]   req_addr;
	logic [DAM_CODE_W-1:0] req_code;
	logic                  req_ap;
	logic                  req_gang;
	logic                  rsp_valid;
	logic [DAM_BANK_W-1:0] rsp_bank;
	logic [DAM_ROW_W-1:0]  rsp_row;
	logic [DAM_COL_W-1:0]  rsp_col;
	logic                  rsp_chan;
	logic                  rsp_rsvd;

	modport requester (
		output req_valid, req_addr, req_code, req_ap, req_gang,
		input  rsp_valid, rsp_bank, rsp_row, rsp_col, rsp_chan,
		input  rsp_rsvd
	);
	modport mapper (
		input  req_valid, req_addr, req_code, req_ap, req_gang,
		output rsp_valid, rsp_bank, rsp_row, rsp_col, rsp_chan,
		output rsp_rsvd
	);
endinterface : dam_xlat_if

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import dam_pkg::*;
	// per map code: low rows, upper rows, bank low bit, bank bit count
	localparam int LO [0:11] = '{9,10,11,11,11,12,12,13,13,14,14,15};
	localparam int UP [0:11] = '{4,3,3,2,2,2,2,2,1,1,2,1};
	localparam int BLO [0:11] = '{12,13,13,14,13,13,14,13,14,14,13,14};
	localparam int NB [0:11] = '{2,2,2,2,3,3,2,3,3,3,3,3};
	localparam logic [11:0] C11 = 12'hB48;

	logic        clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        mvalid, mdone, slow, err;
	logic [7:0]  mcs, cnt, lcs;
	logic [2:0]  mbank, lbank, ob;
	logic [15:0] maddr, laddr, orow, ocol;
	logic        xv, xap, ov, och, ores;
	logic [1:0]  xd;
	logic [39:0] xa;
	int          errors, tests_run;

	dam_top i_dam_top (
		.i_core_clk(clk), .i_reset(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_mode_cmd_valid(mvalid),
		.o_mode_cmd_cs(mcs), .o_mode_cmd_bank(mbank),
		.o_mode_cmd_addr(maddr), .i_mode_cmd_done(mdone),
		.i_xlat_valid(xv), .i_xlat_dimm(xd), .i_xlat_addr(xa),
		.i_xlat_ap(xap), .o_xlat_valid(ov), .o_xlat_bank(ob),
		.o_xlat_row(orow), .o_xlat_col(ocol), .o_xlat_channel(och),
		.o_xlat_reserved(ores)
	);

	dam_seq_model i_dam_seq_model (
		.i_core_clk(clk), .i_reset(rst), .i_slow(slow),
		.i_mode_cmd_valid(mvalid), .i_mode_cmd_cs(mcs),
		.i_mode_cmd_bank(mbank), .i_mode_cmd_addr(maddr),
		.o_mode_cmd_done(mdone), .o_cmd_count(cnt), .o_last_cs(lcs),
		.o_last_bank(lbank), .o_last_addr(laddr)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic test_done;
		if (errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic timeout_hit;
		check(40'h0, 40'h1);
		test_done;
	endtask : timeout_hit

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rdv, output logic e);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) timeout_hit;
		rdv = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic t_regs;
		apb(1'b0, DAM_OFF_MAP, 32'h0, rd, err);
		check(rd, 40'h0);
		apb(1'b1, DAM_OFF_MAP, 32'hFFFF_FFFF, rd, err);
		apb(1'b0, DAM_OFF_MAP, 32'h0, rd, err);
		check(rd, 40'hFFFF);
		apb(1'b1, 8'h00, 32'h1234_5678, rd, err);
		check(err, 40'h1);
		apb(1'b0, 8'h00, 32'h0, rd, err);
		check({err, rd}, 40'h1_0000_0000);
	endtask : t_regs

	task automatic mode_cmd(input logic [2:0] cs, input logic [3:0] cfg,
		input logic s);
		logic [7:0]  n0, expm;
		logic        use_fld;
		logic [31:0] wv;
		int          n;
		slow <= s;
		apb(1'b1, DAM_OFF_CFG, {28'h0, cfg}, rd, err);
		use_fld = (cfg[1] & cfg[2]) ? cfg[0] : !cfg[0];
		expm = use_fld ? (8'h01 << cs) : 8'hFF;
		wv = {5'h0, 1'b1, 3'h0, cs, 1'b0, cs, 16'hA5C0 ^ {13'h0, cs}};
		n0 = cnt;
		apb(1'b1, DAM_OFF_INIT_CMD, wv, rd, err);
		n = 0;
		while (cnt == n0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (cnt == n0) timeout_hit;
		check(lcs, expm);
		check({lbank, laddr}, {cs, wv[15:0]});
		n = 0;
		do begin
			apb(1'b0, DAM_OFF_STAT, 32'h0, rd, err);
			n++;
		end while (rd[0] !== 1'b0 && n < 20);
		if (rd[0] !== 1'b0) timeout_hit;
		apb(1'b0, DAM_OFF_INIT_CMD, 32'h0, rd, err);
		check(rd, wv & 32'hFBFF_FFFF);
		check(cnt, n0 + 8'h01);
	endtask : mode_cmd

	task automatic t_mode;
		logic [3:0] cfgs [0:3];
		cfgs = '{4'h0, 4'h1, 4'h6, 4'h7};
		for (int k = 0; k < 4; k++) begin
			for (int c = 0; c < 8; c++) begin
				mode_cmd(c[2:0], cfgs[k], c[0]);
			end
		end
		// writing zero to the issue bit must not launch a command
		apb(1'b1, DAM_OFF_INIT_CMD, 32'h0030_0000, rd, err);
		repeat (6) @(posedge clk);
		check(cnt, 8'h20);
		apb(1'b0, DAM_OFF_INIT_CMD, 32'h0, rd, err);
		check(rd, 40'h0030_0000);
	endtask : t_mode

	task automatic xlat(input logic [3:0] c, input logic [1:0] d,
		input logic [39:0] a, input logic ap, input logic g);
		logic [39:0] pa;
		logic [2:0]  b;
		logic [15:0] r, col;
		int          k;
		pa = g ? (a >> 1) : a;
		b = 3'h0;
		r = 16'h0;
		col = 16'h0;
		k = c;
		if (c < 4'hC) begin
			for (int i = 0; i < NB[k]; i++) b[i] = pa[BLO[k] + i];
			for (int i = 0; i < LO[k]; i++) r[i] = pa[18 + i];
			for (int j = 0; j < UP[k]; j++) r[LO[k] + j] = pa[18 - UP[k] + j];
			for (int i = 0; i < (k == 0 ? 9 : 10); i++) col[i] = pa[3 + i];
			col[10] = ap;
			if (C11[k]) col[11] = pa[13];
		end
		@(posedge clk);
		xv  <= 1'b1;
		xd  <= d;
		xa  <= a;
		xap <= ap;
		@(posedge clk);
		xv <= 1'b0;
		@(negedge clk);
		check(ov, 40'h1);
		check(ob, b);
		check(orow, r);
		check(ocol, col);
		check(och, g & a[3]);
		check(ores, c > 4'hB);
	endtask : xlat

	task automatic t_xlat;
		logic [15:0] map;
		logic [3:0]  c;
		logic [1:0]  d;
		for (int g = 0; g < 2; g++) begin
			apb(1'b1, DAM_OFF_CFG, {28'h0, g[0], 3'h0}, rd, err);
			for (int ci = 0; ci < 16; ci++) begin
				c = ci[3:0];
				// reversed index so that dimm 3 also meets code 0
				d = ~ci[1:0];
				// the other DIMMs get a different code
				map = {4{~c}};
				map[4 * d +: 4] = c;
				apb(1'b1, DAM_OFF_MAP, {16'h0, map}, rd, err);
				xlat(c, d, 40'hA5_F0C3_5A96, g[0], g[0]);
				xlat(c, d, 40'h5A_0F3C_A569, ~g[0], g[0]);
			end
		end
	endtask : t_xlat

	initial begin
		errors    = 0;
		tests_run = 0;
		rst       = 1'b1;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		slow      = 1'b0;
		xv        = 1'b0;
		xd        = 2'h0;
		xa        = 40'h0;
		xap       = 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_mode;
		t_xlat;
		test_done;
	end
endmodule : tb_top
